/* File: hw/sca_consts.vh */
// constants for the shared counter array
`ifndef SCA_CONSTS_VH
`define SCA_CONSTS_VH
// module mode register bit positions
`define SCA_MODE_IRQ_ON 0
`define SCA_MODE_DUTY 1
`define SCA_MODE_TOGGLE 2
`define SCA_MODE_MATCH 3
`define SCA_MODE_FALL 4
`define SCA_MODE_RISE 5
`define SCA_MODE_COMP 6
// counter mode register bit positions
`define SCA_COUNTER_MODE_REG_WRAP_IRQ 0
`define SCA_COUNTER_MODE_REG_SRC_LO 1
`define SCA_COUNTER_MODE_REG_SRC_HI 2
`define SCA_COUNTER_MODE_REG_WDOG 6
// count source codes
`define SCA_SRC_T0 2'h2
`define SCA_SRC_EXT 2'h3
// internal clock divide ratio
`define SCA_PRESCALE 3'h6
// watchdog module index
`define SCA_WDOG_MODULE 4
// reset values
`define SCA_RESET_BYTE 8'h00
`define SCA_RESET_WORD 16'h0000
`endif

/* File: hw/sca_module.v */
// one compare/capture module of the shared counter array
`timescale 1ns/1ns
`default_nettype none
`include "sca_consts.vh"
module sca_module
(
   input wire clk,
   input wire reset,
   input wire tick,
   input wire [15:0] count,
   input wire [7:0] modeReg,
   input wire pinSync,
   input wire wrLow,
   input wire wrHigh,
   input wire [7:0] wrData,
   output reg [7:0] compareLow,
   output reg [7:0] compareHigh,
   output wire captureEvent,
   output wire matchEvent,
   output reg moduleOut
);
   reg pinPrev;
   wire compOn = modeReg[`SCA_MODE_COMP];
   wire dutyMode = compOn && modeReg[`SCA_MODE_DUTY];
   wire rise = pinSync && !pinPrev;
   wire fall = !pinSync && pinPrev;
   assign captureEvent = (modeReg[`SCA_MODE_RISE] && rise) || (modeReg[`SCA_MODE_FALL] && fall);
   // a match is judged on the count that is present when the counter steps
   wire equal = (count == {compareHigh, compareLow});
   assign matchEvent = tick && compOn && modeReg[`SCA_MODE_MATCH] && !dutyMode && equal;
   wire lowWrap = tick && (count[7:0] == 8'hff);

   always @(posedge clk)
   begin
      if (reset)
      begin
         pinPrev <= 1'b1;
         compareLow <= `SCA_RESET_BYTE;
         compareHigh <= `SCA_RESET_BYTE;
         moduleOut <= 1'b1;
      end
      else
      begin
         pinPrev <= pinSync;
         if (captureEvent)
         begin
            compareLow <= count[7:0];
            compareHigh <= count[15:8];
         end
         else
         begin
            if (wrHigh)
               compareHigh <= wrData;
            if (dutyMode && lowWrap)
               compareLow <= compareHigh;
            else if (wrLow)
               compareLow <= wrData;
         end
         if (dutyMode)
            moduleOut <= (count[7:0] >= compareLow);
         else if (tick && compOn && modeReg[`SCA_MODE_MATCH] && modeReg[`SCA_MODE_TOGGLE] && equal)
            moduleOut <= ~moduleOut;
      end
   end
endmodule // sca_module
`default_nettype wire

/* File: hw/sca_counter_array.v */
// shared 16-bit counter with five compare/capture modules and watchdog
`timescale 1ns/1ns
`default_nettype none
`include "sca_consts.vh"
// What this block does
// - capture enabled by edge selects copies counter into module capture pair
// - module interrupt only when event flag and its interrupt enable are set
// - comparator and match enables give an event when counter equals compare
// - toggle, match and comparator enables invert module pin on each match
// - duty mode needs duty and comparator enables; all share one frequency
// - duty output low while low byte below compare low, else high
// - in duty mode, on low byte wrap, compare low reloads from compare high
// - only module 4 offers watchdog; it stays usable in other modes
// - watchdog match raises internal reset, never drives external reset pin
// - clearing watchdog enable before match prevents reset; setting restores
// - event flag set by hardware on match or capture, cleared by zero write
// - counter runs only when run bit set; wrap sets flag, may interrupt
// - source codes 0,1 oscillator/6, 2 timer 0 overflow, 3 external pin
module sca_counter_array
#(
   parameter MODULES = 5
)
(
   input wire clk,
   input wire reset,
   input wire [7:0] counterModeReg,
   input wire counterRun,
   input wire timer0Overflow,
   input wire externalCountInput,
   input wire [8*MODULES-1:0] moduleModeReg,
   input wire [MODULES-1:0] moduleIoPinIn,
   input wire counterWrite,
   input wire [15:0] counterWriteData,
   input wire [MODULES-1:0] compareLowWrite,
   input wire [MODULES-1:0] compareHighWrite,
   input wire [7:0] compareWriteData,
   input wire flagWrite,
   input wire [7:0] flagWriteData,
   output reg [7:0] counterLowByte,
   output reg [7:0] counterHighByte,
   output wire [7:0] counterControlReg,
   output wire [8*MODULES-1:0] moduleCompareLow,
   output wire [8*MODULES-1:0] moduleCompareHigh,
   output wire [MODULES-1:0] moduleIoPinOut,
   output wire [MODULES-1:0] moduleIoPinOe_n,
   output wire arrayIrq,
   output reg watchdogReset
);
   // true when a byte sits at its top value and the next step carries out
   function byteFull;
      input [7:0] value;
      begin
         byteFull = (value == 8'hff);
      end
   endfunction

   // a module owns its pin only while its comparator steers the output level
   function drivesPin;
      input [7:0] mode;
      begin
         drivesPin = mode[`SCA_MODE_COMP] && (mode[`SCA_MODE_DUTY] || mode[`SCA_MODE_TOGGLE]);
      end
   endfunction

   reg [2:0] prescale;
   reg extSync1;
   reg extSync2;
   reg extPrev;
   reg [MODULES-1:0] pinSync1;
   reg [MODULES-1:0] pinSync2;
   reg counterWrapFlag;
   reg [MODULES-1:0] moduleEventFlag;
   wire [MODULES-1:0] capEv;
   wire [MODULES-1:0] matchEv;
   wire [MODULES-1:0] modOut;
   wire [15:0] count = {counterHighByte, counterLowByte};
   wire [1:0] srcSel = {counterModeReg[`SCA_COUNTER_MODE_REG_SRC_HI], counterModeReg[`SCA_COUNTER_MODE_REG_SRC_LO]};
   wire watchdogArm = counterModeReg[`SCA_COUNTER_MODE_REG_WDOG];
   reg srcPulse;
   wire tick = counterRun && srcPulse;
   wire wrap = tick && byteFull(counterHighByte) && byteFull(counterLowByte);
   wire [MODULES-1:0] moduleIrqOn;
   wire [MODULES-1:0] flagSet = capEv | matchEv;
   reg [2:0] next_prescale;
   reg [7:0] next_counterLowByte;
   reg [7:0] next_counterHighByte;
   reg next_counterWrapFlag;
   reg [MODULES-1:0] next_moduleEventFlag;
   reg next_watchdogReset;

   always @*
   begin
      if (srcSel == `SCA_SRC_T0)
         srcPulse = timer0Overflow;
      else if (srcSel == `SCA_SRC_EXT)
         srcPulse = extSync2 && !extPrev;
      else
         srcPulse = (prescale == `SCA_PRESCALE - 3'h1);
   end

   // prescaler wraps after the divide ratio
   always @*
   begin
      if (prescale == `SCA_PRESCALE - 3'h1)
         next_prescale = 3'h0;
      else
         next_prescale = prescale + 3'h1;
   end

   // a software load wins over a step of the counter
   always @*
   begin
      next_counterLowByte = counterLowByte;
      next_counterHighByte = counterHighByte;
      if (counterWrite)
      begin
         next_counterLowByte = counterWriteData[7:0];
         next_counterHighByte = counterWriteData[15:8];
      end
      else if (tick)
      begin
         next_counterLowByte = counterLowByte + 8'h01;
         if (byteFull(counterLowByte))
            next_counterHighByte = counterHighByte + 8'h01;
      end
   end

   // hardware set wins over a software clear in the same cycle
   always @*
   begin
      next_counterWrapFlag = counterWrapFlag;
      if (wrap)
         next_counterWrapFlag = 1'b1;
      else if (flagWrite)
         next_counterWrapFlag = flagWriteData[7];
      next_moduleEventFlag = moduleEventFlag;
      if (flagWrite)
         next_moduleEventFlag = moduleEventFlag & flagWriteData[MODULES-1:0];
      next_moduleEventFlag = next_moduleEventFlag | flagSet;
   end

   // module 4 match while armed; disarming before the match suppresses the reset
   always @*
   begin
      next_watchdogReset = 1'b0;
      if (watchdogArm && matchEv[`SCA_WDOG_MODULE])
         next_watchdogReset = 1'b1;
   end

   // prescaler and synchronisers for the pins and the external count input
   always @(posedge clk)
   begin
      if (reset)
      begin
         prescale <= 3'h0;
         extSync1 <= 1'b0;
         extSync2 <= 1'b0;
         extPrev <= 1'b0;
         pinSync1 <= {MODULES{1'b1}};
         pinSync2 <= {MODULES{1'b1}};
      end
      else
      begin
         prescale <= next_prescale;
         extSync1 <= externalCountInput;
         extSync2 <= extSync1;
         extPrev <= extSync2;
         pinSync1 <= moduleIoPinIn;
         pinSync2 <= pinSync1;
      end
   end

   // counter, flags and the single-cycle watchdog reset pulse
   always @(posedge clk)
   begin
      if (reset)
      begin
         counterLowByte <= `SCA_RESET_BYTE;
         counterHighByte <= `SCA_RESET_BYTE;
         counterWrapFlag <= 1'b0;
         moduleEventFlag <= {MODULES{1'b0}};
         watchdogReset <= 1'b0;
      end
      else
      begin
         counterLowByte <= next_counterLowByte;
         counterHighByte <= next_counterHighByte;
         counterWrapFlag <= next_counterWrapFlag;
         moduleEventFlag <= next_moduleEventFlag;
         watchdogReset <= next_watchdogReset;
      end
   end

   genvar i;
   generate
      for (i = 0; i < MODULES; i = i + 1)
      begin : gMod
         assign moduleIrqOn[i] = moduleModeReg[8*i+`SCA_MODE_IRQ_ON];
         // capture-only modules leave the pin as input
         assign moduleIoPinOe_n[i] = !drivesPin(moduleModeReg[8*i+7:8*i]);
         assign moduleIoPinOut[i] = modOut[i];
         sca_module uMod
         (
            .clk(clk),
            .reset(reset),
            .tick(tick),
            .count(count),
            .modeReg(moduleModeReg[8*i+7:8*i]),
            .pinSync(pinSync2[i]),
            .wrLow(compareLowWrite[i]),
            .wrHigh(compareHighWrite[i]),
            .wrData(compareWriteData),
            .compareLow(moduleCompareLow[8*i+7:8*i]),
            .compareHigh(moduleCompareHigh[8*i+7:8*i]),
            .captureEvent(capEv[i]),
            .matchEvent(matchEv[i]),
            .moduleOut(modOut[i])
         );
      end
   endgenerate

   assign counterControlReg = {counterWrapFlag, counterRun, 1'b0, moduleEventFlag[4:0]};
   assign arrayIrq = |(moduleEventFlag & moduleIrqOn)
      || (counterWrapFlag && counterModeReg[`SCA_COUNTER_MODE_REG_WRAP_IRQ]);
endmodule // sca_counter_array
`default_nettype wire

/* File: tb/sca_props.sv */
// assertion checker for the shared counter array ports
`timescale 1ns/1ns
`default_nettype none
module sca_props
#(
   parameter MODULES = 5
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] counterModeReg,
   input wire logic counterRun,
   input wire logic [8*MODULES-1:0] moduleModeReg,
   input wire logic counterWrite,
   input wire logic flagWrite,
   input wire logic [7:0] counterLowByte,
   input wire logic [7:0] counterHighByte,
   input wire logic [7:0] counterControlReg,
   input wire logic [8*MODULES-1:0] moduleCompareLow,
   input wire logic [8*MODULES-1:0] moduleCompareHigh,
   input wire logic [MODULES-1:0] moduleIoPinOut,
   input wire logic [MODULES-1:0] moduleIoPinOe_n,
   input wire logic arrayIrq,
   input wire logic watchdogReset
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire [7:0] ccr = counterControlReg;
   wire [7:0] m0 = moduleModeReg[7:0];
   wire [7:0] m1 = moduleModeReg[15:8];
   wire [7:0] m4 = moduleModeReg[39:32];
   wire [15:0] cnt = {counterHighByte, counterLowByte};
   wire [4:0] ie = {m4[0], moduleModeReg[24], moduleModeReg[16], m1[0], m0[0]};
   wire tog1 = m1[6] & m1[3] & m1[2] & !m1[1];
   wire hit1 = cnt == {moduleCompareHigh[15:8], moduleCompareLow[15:8]};
   wire wdHit = counterModeReg[6] & m4[6] & m4[3] & (cnt == {moduleCompareHigh[39:32], moduleCompareLow[39:32]});
   wire geq0 = counterLowByte >= moduleCompareLow[7:0];
   chk_irq_level: assert property (
      arrayIrq == (ccr[7] & counterModeReg[0] | (|(ccr[4:0] & ie)))) else $error("irq level");
   chk_run_hold: assert property (
      !counterRun && !$past(counterRun) && !counterWrite && !watchdogReset |=> $stable(cnt)) else $error("count moved");
   chk_flag_hold: assert property (
      !flagWrite && !watchdogReset |=> (ccr & $past(ccr) & 8'h9f) == ($past(ccr) & 8'h9f)) else $error("flag lost");
   chk_wdog_pulse: assert property (watchdogReset |=> !watchdogReset) else $error("wdog width");
   chk_wdog_cause: assert property (watchdogReset |-> $past(wdHit)) else $error("wdog cause");
   chk_duty_level: assert property (m0[6] & m0[1] |=> moduleIoPinOut[0] == $past(geq0)) else $error("duty");
   chk_toggle_cause: assert property (
      $past(tog1) && moduleIoPinOut[1] != $past(moduleIoPinOut[1]) |-> $past(hit1)) else $error("toggle");
   chk_oe_drive: assert property (
      moduleIoPinOe_n[0] == !(m0[6] & (m0[1] | m0[2]))) else $error("pin enable");
endmodule // sca_props
bind sca_counter_array sca_props #(.MODULES(MODULES)) u_props
(
   .clk(clk),
   .reset(reset),
   .counterModeReg(counterModeReg),
   .counterRun(counterRun),
   .moduleModeReg(moduleModeReg),
   .counterWrite(counterWrite),
   .flagWrite(flagWrite),
   .counterLowByte(counterLowByte),
   .counterHighByte(counterHighByte),
   .counterControlReg(counterControlReg),
   .moduleCompareLow(moduleCompareLow),
   .moduleCompareHigh(moduleCompareHigh),
   .moduleIoPinOut(moduleIoPinOut),
   .moduleIoPinOe_n(moduleIoPinOe_n),
   .arrayIrq(arrayIrq),
   .watchdogReset(watchdogReset)
);
`default_nettype wire

/* File: tb/sca_pin_model.sv */
// pins of the modules: outside driver with pull-up
`timescale 1ns/1ns
`default_nettype none
module sca_pin_model
(
   input wire logic [4:0] pinOut,
   input wire logic [4:0] pinOe_n,
   input wire logic [4:0] extEn,
   input wire logic [4:0] extLevel,
   output logic [4:0] pinIn
);
   assign pinIn = (~pinOe_n & pinOut) | (pinOe_n & ((extEn & extLevel) | ~extEn));
endmodule // sca_pin_model
`default_nettype wire

/* File: tb/tb_counter_array_capture_pwm_wdt.sv */
// self-checking bench for the shared counter array
`timescale 1ns/1ns
`default_nettype none
module tb_counter_array_capture_pwm_wdt;
   logic clk, reset, run, t0, ext, cWr, fWr, irq, wdr;
   logic [7:0] cmr, wData, fData, lo, hi, ccr;
   logic [39:0] mmr, cmpL, cmpH;
   logic [15:0] cData, capE;
   logic [4:0] lWr, hWr, pOut, oeN, pIn, extEn, extLvl;
   int errTotal, nChecks, wdN, i;
   sca_counter_array u_dut (.clk(clk), .reset(reset), .counterModeReg(cmr), .counterRun(run),
      .timer0Overflow(t0), .externalCountInput(ext), .moduleModeReg(mmr), .moduleIoPinIn(pIn),
      .counterWrite(cWr), .counterWriteData(cData), .compareLowWrite(lWr), .compareHighWrite(hWr),
      .compareWriteData(wData), .flagWrite(fWr), .flagWriteData(fData), .counterLowByte(lo),
      .counterHighByte(hi), .counterControlReg(ccr), .moduleCompareLow(cmpL), .moduleCompareHigh(cmpH),
      .moduleIoPinOut(pOut), .moduleIoPinOe_n(oeN), .arrayIrq(irq), .watchdogReset(wdr));
   sca_pin_model u_pins (.pinOut(pOut), .pinOe_n(oeN), .extEn(extEn), .extLevel(extLvl), .pinIn(pIn));
   initial
   begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) if (wdr === 1'b1) wdN++;
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task pulses(input int n);
      repeat (n)
      begin
         t0 = 1;
         cyc(1);
         t0 = 0;
         cyc(1);
      end
   endtask
   task wr16(input [15:0] d);
      cData = d;
      cWr = 1;
      cyc(1);
      cWr = 0;
   endtask
   task wcmp(input int m, input [15:0] d);
      wData = d[7:0];
      lWr = 5'h01 << m;
      cyc(1);
      lWr = 5'h00;
      wData = d[15:8];
      hWr = 5'h01 << m;
      cyc(1);
      hWr = 5'h00;
   endtask
   task chk(input string nm, input [15:0] e, input [15:0] g);
      nChecks++;
      if (g !== e)
      begin
         errTotal++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task finishTest;
      $display("checks %0d mismatches %0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      #20000;
      errTotal++;
      finishTest;
   end
   initial
   begin
      {run, t0, ext, cWr, fWr, cmr, mmr, cData, lWr, hWr, wData, fData, extLvl, wdN} = '0;
      {reset, extEn} = 6'h24;
      cyc(12);
      reset = 0;
      chk("pins", 16'h1f, pOut);
      cmr = 8'h04;
      run = 1;
      pulses(3);
      chk("count", 3, {hi, lo});
      run = 0;
      pulses(2);
      chk("held", 3, {hi, lo});
      for (i = 0; i < 2; i++)
      begin
         cmr = {6'h00, i[0], 1'b0};
         run = 1;
         cyc(1);
         capE = {hi, lo};
         cyc(12);
         chk("prescale", capE + 16'h2, {hi, lo});
      end
      $display("counter test done");
      mmr = 40'h4d00;
      cmr = 8'h04;
      wcmp(1, 16'h0010);
      wr16(16'h000f);
      pulses(2);
      cyc(1);
      chk("toggle", 0, pOut[1]);
      chk("flags", 16'h42, ccr);
      chk("irq", 1, irq);
      mmr = 40'h4c00;
      cyc(1);
      chk("irq off", 0, irq);
      fWr = 1;
      cyc(1);
      fWr = 0;
      chk("cleared", 16'h40, ccr);
      $display("timer test done");
      run = 0;
      capE = 0;
      for (i = 0; i < 6; i++)
      begin
         mmr = (i < 2) ? 40'h200000 : (i < 4) ? 40'h100000 : 40'h300000;
         wr16(16'h0100 + i);
         extLvl[2] = ~i[0];
         cyc(5);
         if (i == 0 || i > 2) capE = 16'h0100 + i;
         chk("capture", capE, {cmpH[23:16], cmpL[23:16]});
      end
      $display("capture test done");
      mmr = 40'h42;
      wcmp(0, 16'h4080);
      wr16(16'h00fe);
      cyc(1);
      chk("duty hi", 1, pOut[0]);
      run = 1;
      pulses(2);
      cyc(1);
      chk("reload", 16'h40, cmpL[7:0]);
      chk("duty lo", 0, pOut[0]);
      wr16(16'h0140);
      cyc(1);
      chk("duty eq", 1, pOut[0]);
      $display("duty test done");
      mmr = 40'h4800000000;
      for (i = 0; i < 3; i++)
      begin
         cmr = (i == 1) ? 8'h04 : 8'h44;
         wcmp(4, 16'h0200);
         wr16(16'h01ff);
         pulses(2);
         chk("wdog", (i + 2) / 2, wdN);
      end
      for (i = 0; i < 4; i++)
      begin
         wcmp(4, {hi, lo} + 16'h0004);
         pulses(2);
      end
      chk("wdog held", 2, wdN);
      cmr = 8'h04;
      mmr = 40'h4c00000000;
      wcmp(4, {hi, lo} + 16'h0001);
      pulses(2);
      chk("mod4 toggle", 0, pOut[4]);
      chk("no wdog", 2, wdN);
      $display("watchdog test done");
      mmr = 40'h0;
      cmr = 8'h07;
      fWr = 1;
      wr16(16'hfffe);
      fWr = 0;
      repeat (3)
      begin
         ext = 1;
         cyc(2);
         ext = 0;
         cyc(2);
      end
      chk("ext count", 16'h0001, {hi, lo});
      chk("wrap flag", 16'hc0, ccr);
      chk("wrap irq", 1, irq);
      $display("wrap test done");
      finishTest;
   end
endmodule // tb_counter_array_capture_pwm_wdt
`default_nettype wire
